/* File: logic/gcl_pkg.sv */
// constants and types for the companding and loopback block
package gcl_pkg;
  // register map
  localparam logic [6:0]  GCL_CTRL_OFS     = 7'h05;
  localparam logic [15:0] GCL_CTRL_RST     = 16'h0000;
  // control field positions
  localparam int          GCL_PLAY_LOOP_B  = 6;
  localparam int          GCL_PLAY_LAW_LSB = 3;
  localparam int          GCL_REC_LAW_LSB  = 1;
  localparam int          GCL_REC_LOOP_B   = 0;
  localparam int          GCL_PACKED_B     = 7;
  // law selection codes
  typedef enum logic [1:0] {
    GCL_LAW_OFF  = 2'b00,
    GCL_LAW_RSVD = 2'b01,
    GCL_LAW_MU   = 2'b10,
    GCL_LAW_A    = 2'b11
  } gcl_law_t;
  // inversion masks applied to the code word
  localparam logic [7:0]  GCL_MU_INV       = 8'hff;
  localparam logic [7:0]  GCL_A_INV        = 8'h55;
  // segment and bias figures
  localparam logic [14:0] GCL_MU_BIAS      = 15'h0021;
  localparam logic [14:0] GCL_MU_CLIP      = 15'h1fff;
  localparam logic [15:0] GCL_MU_DBIAS     = 16'h0084;
  localparam logic [15:0] GCL_A_SEG1_ADD   = 16'h0108;
  localparam logic [15:0] GCL_A_SEG0_ADD   = 16'h0008;
  localparam int          GCL_SEGS         = 8;
  // interface word lengths in bits
  localparam logic [5:0]  GCL_WL_PACKED    = 6'h08;
  localparam logic [5:0]  GCL_WL_16        = 6'h10;
  localparam logic [5:0]  GCL_WL_20        = 6'h14;
  localparam logic [5:0]  GCL_WL_24        = 6'h18;
  localparam logic [5:0]  GCL_WL_32        = 6'h20;
endpackage

/* File: logic/gcl_law.sv */
// combinational g.711 segment encoder and decoder
`timescale 1ns/100ps
module gcl_law
  import gcl_pkg::*;
(
  input  wire logic [15:0] linIn,   // linear sample to compress
  input  wire gcl_law_t    encLaw,  // law for compression
  output logic      [7:0]  codeOut, // transmitted code, inversion applied
  input  wire logic [7:0]  codeIn,  // received code, inversion still applied
  input  wire gcl_law_t    decLaw,  // law for expansion
  output logic      [15:0] linOut   // expanded sample, left aligned
);

  // mu-law: 14-bit signed source, 13-bit magnitude after bias
  function automatic logic [7:0] muEnc(input logic [15:0] s);
    logic [13:0] s14;
    logic [14:0] mag;
    logic [2:0]  seg;
    logic [14:0] sh;
    logic        found;
    s14   = s[15:2];
    mag   = s14[13] ? 15'(-$signed({s14[13], s14})) : {1'b0, s14};
    mag   = mag + GCL_MU_BIAS;
    if (mag > GCL_MU_CLIP) mag = GCL_MU_CLIP;  // clip keeps segment 7 the top
    seg   = 3'h7;
    found = 1'b0;
    // eight segments, each doubling the step size
    for (int i = 0; i < GCL_SEGS; i++) begin
      if (!found && mag < (15'h0040 << i)) begin
        seg   = 3'(i);
        found = 1'b1;
      end
    end
    // shift widened so segment 7 moves by eight, not wrapping to zero
    sh    = mag >> ({1'b0, seg} + 4'h1);
    // sign, exponent, mantissa, all bits inverted
    return {~s14[13], seg, sh[3:0]} ^ GCL_MU_INV ^ 8'h80;
  endfunction

  // a-law: 13-bit signed source, 12-bit magnitude
  function automatic logic [7:0] aEnc(input logic [15:0] s);
    logic [12:0] s13;
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [11:0] sh;
    logic        found;
    s13   = s[15:3];
    mag   = s13[12] ? ~s13[11:0] : s13[11:0];
    seg   = 3'h0;
    found = 1'b0;
    for (int i = 0; i < GCL_SEGS; i++) begin
      if (!found && {1'b0, mag} < (13'h0020 << i)) begin
        seg   = 3'(i);
        found = 1'b1;
      end
    end
    sh    = (seg < 3'h2) ? (mag >> 1) : (mag >> seg);
    // positive samples carry sign 1; even bits inverted
    return {~s13[12], seg, sh[3:0]} ^ GCL_A_INV;
  endfunction

  // mu-law expansion back to 14 bits, left aligned in 16
  function automatic logic [15:0] muDec(input logic [7:0] c);
    logic [7:0]  u;
    logic [15:0] t;
    u = c ^ GCL_MU_INV;
    t = (({12'h000, u[3:0]} << 3) + GCL_MU_DBIAS) << u[6:4];
    return u[7] ? (GCL_MU_DBIAS - t) : (t - GCL_MU_DBIAS);
  endfunction

  // a-law expansion back to 13 bits, left aligned in 16
  function automatic logic [15:0] aDec(input logic [7:0] c);
    logic [7:0]  a;
    logic [15:0] t;
    a = c ^ GCL_A_INV;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) t = t + GCL_A_SEG0_ADD;
    else t = (t + GCL_A_SEG1_ADD) << (a[6:4] - 3'h1);
    return a[7] ? t : 16'(-t);
  endfunction

  // law select per direction; reserved code never reaches here as a law
  always_comb begin
    unique case (encLaw)
      GCL_LAW_MU: codeOut = muEnc(linIn);
      GCL_LAW_A:  codeOut = aEnc(linIn);
      default:    codeOut = 8'h00;
    endcase
    unique case (decLaw)
      GCL_LAW_MU: linOut = muDec(codeIn);
      GCL_LAW_A:  linOut = aDec(codeIn);
      default:    linOut = 16'h0000;
    endcase
  end

endmodule // gcl_law

/* File: logic/gcl_codec.sv */
// companding and digital loopback between record and playback interfaces
`timescale 1ns/100ps
module gcl_codec
  import gcl_pkg::*;
(
  input  wire logic        mclk,            // block clock, 25 MHz
  input  wire logic        rst_n,           // async reset, active low
  input  wire logic        ce,              // clock enable, freezes all state
  input  wire logic        regWrite,        // register write strobe
  input  wire logic [6:0]  regAddr,         // register address
  input  wire logic [15:0] regWrData,       // register write data
  output logic      [15:0] regRdData,       // registered read data
  input  wire logic [1:0]  audioWordLength, // normal interface word length
  output logic      [5:0]  effWordLen,      // word length in force, bits
  input  wire logic [15:0] recSample,       // linear record sample
  input  wire logic        recSampleValid,  // record sample strobe
  output logic      [31:0] recWord,         // record interface word, msb aligned
  output logic             recWordValid,    // record word strobe
  input  wire logic [31:0] playWord,        // received playback word, msb aligned
  input  wire logic        playWordValid,   // playback word strobe
  output logic      [15:0] playSample,      // linear playback sample
  output logic             playSampleValid  // playback sample strobe
);

  // all state of the block
  typedef struct packed {
    logic [7:0]  ctrl;       // control bits, bit 7 is the packed option
    logic [15:0] rdData;     // read data
    logic [5:0]  wordLen;    // effective word length
    logic [31:0] recWord;    // record word
    logic        recValid;   // record strobe
    logic [15:0] playSample; // playback sample
    logic        playValid;  // playback strobe
  } gcl_state_t;

  gcl_state_t stQ;  // registered state
  gcl_state_t stD;  // next state

  gcl_law_t   recLaw;      // law in force on the record side
  gcl_law_t   playLaw;     // law in force on the playback side
  logic [7:0] encCode;     // compressed record code
  logic [15:0] decSample;  // expanded playback sample
  logic [31:0] recNext;    // record word about to be sent
  logic        recNextV;   // its strobe
  logic [31:0] playIn;     // word entering the playback path
  logic        playInV;    // its strobe

  // law decode; reserved treated as off
  always_comb begin
    recLaw  = gcl_law_t'(stQ.ctrl[GCL_REC_LAW_LSB +: 2]);
    playLaw = gcl_law_t'(stQ.ctrl[GCL_PLAY_LAW_LSB +: 2]);
    if (recLaw == GCL_LAW_RSVD) recLaw = GCL_LAW_OFF;
    if (playLaw == GCL_LAW_RSVD) playLaw = GCL_LAW_OFF;
  end

  // encoder and decoder share one combinational core
  gcl_law uLaw (
    .linIn   (recSample),
    .encLaw  (recLaw),
    .codeOut (encCode),
    .codeIn  (playIn[31:24]),
    .decLaw  (playLaw),
    .linOut  (decSample)
  );

  // data routing; both loops may be on at once
  always_comb begin
    if (stQ.ctrl[GCL_PLAY_LOOP_B]) begin
      // received word replaces the record input
      recNext  = playWord;
      recNextV = playWordValid;
    end else if (recLaw == GCL_LAW_OFF) begin
      recNext  = {recSample, 16'h0000};
      recNextV = recSampleValid;
    end else begin
      // code in the top byte, lower bits zero
      recNext  = {encCode, 24'h000000};
      recNextV = recSampleValid;
    end
    if (stQ.ctrl[GCL_REC_LOOP_B]) begin
      // record output word drives the playback path
      playIn  = recNext;
      playInV = recNextV;
    end else begin
      playIn  = playWord;
      playInV = playWordValid;
    end
  end

  // next-state logic
  always_comb begin
    stD = stQ;
    if (ce) begin
      // control register write, unused bits dropped
      if (regWrite && regAddr == GCL_CTRL_OFS) begin
        stD.ctrl = regWrData[7:0];
      end
      // read data follows the address one cycle later
      stD.rdData = (regAddr == GCL_CTRL_OFS) ? {8'h00, stQ.ctrl} : 16'h0000;
      // packed option overrides the normal length
      if (stQ.ctrl[GCL_PACKED_B]) begin
        stD.wordLen = GCL_WL_PACKED;
      end else begin
        unique case (audioWordLength)
          2'b00:   stD.wordLen = GCL_WL_16;
          2'b01:   stD.wordLen = GCL_WL_20;
          2'b10:   stD.wordLen = GCL_WL_24;
          2'b11:   stD.wordLen = GCL_WL_32;
        endcase
      end
      stD.recValid  = recNextV;
      stD.playValid = playInV;
      if (recNextV) stD.recWord = recNext;
      if (playInV) begin
        // linear pass-through takes the top 16 bits
        stD.playSample = (playLaw == GCL_LAW_OFF) ? playIn[31:16] : decSample;
      end
    end
  end

  // state register; register defaults on reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stQ.ctrl       <= GCL_CTRL_RST[7:0];
      stQ.rdData     <= 16'h0000;
      stQ.wordLen    <= GCL_WL_16;
      stQ.recWord    <= 32'h00000000;
      stQ.recValid   <= 1'b0;
      stQ.playSample <= 16'h0000;
      stQ.playValid  <= 1'b0;
    end else begin
      stQ <= stD;
    end
  end

  // outputs straight from flops
  assign regRdData       = stQ.rdData;
  assign effWordLen      = stQ.wordLen;
  assign recWord         = stQ.recWord;
  assign recWordValid    = stQ.recValid;
  assign playSample      = stQ.playSample;
  assign playSampleValid = stQ.playValid;

endmodule // gcl_codec

/* File: tb/gcl_codec_assertions.sv */
// port-level checks for the companding and loopback block
`timescale 1ns/100ps
module gcl_codec_assertions
  import gcl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        regWrite,
  input wire logic [6:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic [1:0]  audioWordLength,
  input wire logic [5:0]  effWordLen,
  input wire logic [15:0] recSample,
  input wire logic        recSampleValid,
  input wire logic [31:0] recWord,
  input wire logic        recWordValid,
  input wire logic [31:0] playWord,
  input wire logic        playWordValid,
  input wire logic [15:0] playSample,
  input wire logic        playSampleValid
);
  logic [7:0] ctrl_q; // shadow of the stored control bits
  logic       recGo;  // record sample taken from the record input
  logic       playGo; // playback word taken from the host
  // shadow follows the same write qualifiers as the block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
    end else if (ce && regWrite && regAddr == GCL_CTRL_OFS) begin
      ctrl_q <= regWrData[7:0];
    end
  end
  // law bit 2 or 4 set means a real law; 01 counts as off
  assign recGo = ce && recSampleValid && !ctrl_q[6];
  assign playGo = ce && playWordValid && !ctrl_q[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rec_strobe:
    assert property (recGo || (ce && playWordValid && ctrl_q[6]) |=> recWordValid)
      else $error("record strobe missing");
  a_rec_plain:
    assert property (recGo && !ctrl_q[2] |=> recWord == {$past(recSample), 16'h0000})
      else $error("plain record word wrong");
  a_rec_loop:
    assert property (ce && playWordValid && ctrl_q[6] |=> recWord == $past(playWord))
      else $error("looped record word wrong");
  a_code_top:
    assert property (recGo && ctrl_q[2] |=> recWord[23:0] == 24'h000000)
      else $error("code not in top byte");
  a_play_loop:
    assert property (recGo && ctrl_q[0] |=> playSampleValid)
      else $error("looped playback strobe missing");
  a_play_plain:
    assert property (playGo && !ctrl_q[4] |=>
      {playSample, 16'h0000} == ($past(playWord) & 32'hffff0000))
      else $error("plain playback sample wrong");
  a_packed_len:
    assert property (ce && ctrl_q[7] |=> effWordLen == GCL_WL_PACKED)
      else $error("packed word length wrong");
  a_rd_unmapped:
    assert property (ce && regAddr != GCL_CTRL_OFS |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
endmodule // gcl_codec_assertions

/* File: tb/gcl_host_model.sv */
// host side of the serial audio interface
`timescale 1ns/100ps
module gcl_host_model (
  input  wire logic        mclk,         // block clock
  output logic      [31:0] playWord,     // word sent to the device
  output logic             playWordValid // word strobe
);
  // quiet start: no word offered
  initial begin
    playWord = 32'h00000000;
    playWordValid = 1'b0;
  end
  // one word per call; released line shows the inverse so stale data cannot pass
  task automatic send(input logic [31:0] w);
    @(negedge mclk);
    playWord = w;
    playWordValid = 1'b1;
    @(negedge mclk);
    playWordValid = 1'b0;
    playWord = ~w;
  endtask
endmodule // gcl_host_model

/* File: tb/gcl_codec_test.sv */
// self-checking bench for the companding and loopback block
`timescale 1ns/100ps
module gcl_codec_test
  import gcl_pkg::*;
;
  logic mclk, rst_n, ce, regWrite, recSampleValid, recWordValid, playWordValid, playSampleValid;
  logic [6:0]  regAddr;
  logic [15:0] regWrData, regRdData, recSample, playSample;
  logic [1:0]  audioWordLength;
  logic [5:0]  effWordLen;
  logic [31:0] recWord, playWord;
  int          error_cnt, checks;
  // per-case control, sample, record word, host word, playback sample
  logic [7:0]  tCtrl [8] = '{8'h00, 8'h14, 8'h14, 8'h1e, 8'h1e, 8'h0a, 8'h1c, 8'h16};
  logic [15:0] tSmp  [8] = '{16'h1234, 16'h0000, 16'h7fff, 16'h0000, 16'h7fff, 16'h8001,
                             16'h4000, 16'hffff};
  logic [31:0] tRec  [8] = '{32'h12340000, 32'hff000000, 32'h80000000,
                             32'hd5000000, 32'haa000000, 32'h80010000,
                             32'h8f000000, 32'h55000000};
  logic [31:0] tPlay [8] = '{32'habcd0000, 32'hff000000, 32'h80000000,
                             32'hd5000000, 32'haa000000, 32'h5a5a0000,
                             32'h55000000, 32'h7e000000};
  logic [15:0] tLin  [8] = '{16'habcd, 16'h0000, 16'h7d7c, 16'h0008, 16'h7e00, 16'h5a5a,
                             16'hfff8, 16'hfff8};
  gcl_codec u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .audioWordLength(audioWordLength), .effWordLen(effWordLen), .recSample(recSample),
    .recSampleValid(recSampleValid), .recWord(recWord), .recWordValid(recWordValid),
    .playWord(playWord), .playWordValid(playWordValid), .playSample(playSample),
    .playSampleValid(playSampleValid));
  gcl_host_model u_host (.mclk(mclk), .playWord(playWord), .playWordValid(playWordValid));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask
  // read data is registered: look one cycle after the address
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(negedge mclk);
    regAddr = a;
    @(negedge mclk);
    chk("regRdData", {16'h0000, e}, {16'h0000, regRdData});
  endtask
  task automatic rec(input logic [15:0] s, input logic [31:0] e);
    @(negedge mclk);
    recSample = s;
    recSampleValid = 1'b1;
    @(negedge mclk);
    recSampleValid = 1'b0;
    recSample = ~s;
    chk("recWordValid", 32'h1, {31'h0, recWordValid});
    chk("recWord", e, recWord);
  endtask
  task automatic play(input logic [31:0] w, input logic [15:0] e);
    u_host.send(w);
    chk("playSampleValid", 32'h1, {31'h0, playSampleValid});
    chk("playSample", {16'h0000, e}, {16'h0000, playSample});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    for (int n = 0; n < 5000; n++) @(posedge mclk);
    error_cnt++;
    complete_run;
  end
  initial begin
    {rst_n, regWrite, recSampleValid, recSample, regWrData, audioWordLength} = '0;
    ce = 1'b1;
    regAddr = GCL_CTRL_OFS;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(negedge mclk);
    chk("effWordLen", 32'h10, {26'h0, effWordLen});
    rst_n = 1'b1;
    // off, mu, a-law, reserved and mixed selections; top segment and negative samples
    for (int i = 0; i < 8; i++) begin
      wr(GCL_CTRL_OFS, {8'h00, tCtrl[i]});
      rec(tSmp[i], tRec[i]);
      play(tPlay[i], tLin[i]);
      $display("test law %0d done", i);
    end
    wr(GCL_CTRL_OFS, 16'hff94);
    rd(GCL_CTRL_OFS, 16'h0094);
    rd(7'h06, 16'h0000);
    chk("effWordLen", 32'h8, {26'h0, effWordLen});
    rec(16'h0000, 32'hff000000);
    wr(GCL_CTRL_OFS, 16'h0000);
    audioWordLength = 2'b10;
    rd(GCL_CTRL_OFS, 16'h0000);
    chk("effWordLen", 32'h18, {26'h0, effWordLen});
    audioWordLength = 2'b01;
    rd(GCL_CTRL_OFS, 16'h0000);
    chk("effWordLen", 32'h14, {26'h0, effWordLen});
    audioWordLength = 2'b11;
    rd(GCL_CTRL_OFS, 16'h0000);
    chk("effWordLen", 32'h20, {26'h0, effWordLen});
    $display("test word length done");
    wr(GCL_CTRL_OFS, 16'h0040);
    u_host.send(32'h13572468);
    chk("recWordValid", 32'h1, {31'h0, recWordValid});
    chk("recWord", 32'h13572468, recWord);
    wr(GCL_CTRL_OFS, 16'h0001);
    rec(16'h4321, 32'h43210000);
    chk("playSampleValid", 32'h1, {31'h0, playSampleValid});
    chk("playSample", 32'h4321, {16'h0000, playSample});
    // both loops on: host word goes to record and on to playback
    wr(GCL_CTRL_OFS, 16'h0041);
    u_host.send(32'h2468ace0);
    chk("recWord", 32'h2468ace0, recWord);
    chk("playSampleValid", 32'h1, {31'h0, playSampleValid});
    chk("playSample", 32'h2468, {16'h0000, playSample});
    $display("test loopback done");
    // clock enable low: a write must not land
    ce = 1'b0;
    wr(GCL_CTRL_OFS, 16'h0094);
    ce = 1'b1;
    rd(GCL_CTRL_OFS, 16'h0041);
    $display("test clock enable done");
    complete_run;
  end
endmodule // gcl_codec_test
bind gcl_codec gcl_codec_assertions u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce),
  .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .audioWordLength(audioWordLength), .effWordLen(effWordLen), .recSample(recSample),
  .recSampleValid(recSampleValid), .recWord(recWord), .recWordValid(recWordValid),
  .playWord(playWord), .playWordValid(playWordValid), .playSample(playSample),
  .playSampleValid(playSampleValid));
